// ---- common/mct_params.svh ----
// Constants of the micro-step current translator: positions, step codes, reset values.
// Assumes inclusion by the translator package and core only.
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH

`define MCT_POS_W 6
`define MCT_CUR_W 11
`define MCT_RESET_POS 6'h08
`define MCT_RESET_CUR 11'h2C3
`define MCT_FULL_SCALE 11'h3E8
`define MCT_RES_16TH 3'h0
`define MCT_RES_8TH 3'h1
`define MCT_RES_4TH 3'h2
`define MCT_RES_HALF 3'h3
`define MCT_RES_FULL 3'h4
`define MCT_HALF_TURN 5'h10

`endif

// ---- common/mct_pkg.sv ----
// Types of the micro-step current translator.
// Assumes mct_params.svh sits in the include path.
`include "mct_params.svh"

package mct_pkg;
	typedef logic [`MCT_POS_W-1:0] mct_pos_t;
	typedef logic signed [`MCT_CUR_W-1:0] mct_cur_t;
	typedef logic [2:0] mct_res_t;
	typedef logic [2:0] mct_shift_t;
endpackage

// ---- core/mct_translator.sv ----
// Step translator: 64-entry position counter and coil X/Y current lookup.
// Assumes one 100 MHz clock; step and direction pins arrive asynchronously,
// the register-side controls come from logic on the same clock.
`timescale 1ns/100ps
`include "mct_params.svh"

module mct_translator (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Pins from the controller
	input wire logic STEP_TRIGGER_PIN_I,
	input wire logic DIRECTION_PIN_I,
	// Control bits
	input wire logic [2:0] STEP_RESOLUTION_SELECT_I,
	input wire logic DIRECTION_POLARITY_BIT_I,
	input wire logic STEP_COMMAND_BIT_SET_I,
	input wire logic POSITION_WRITE_I,
	input wire logic [5:0] POSITION_WDATA_I,
	// Status and currents
	output logic [5:0] TRANSLATOR_POSITION_O,
	output logic STEP_COMMAND_BIT_O,
	output logic DIRECTION_PIN_FLAG_O,
	output logic signed [10:0] COIL_X_O,
	output logic signed [10:0] COIL_Y_O
);
	// Quarter sine in tenths of a percent, index 0..16
	function automatic mct_pkg::mct_cur_t quarter_sine(input logic [4:0] idx);
		mct_pkg::mct_cur_t v;
		v = 11'h000;
		unique case (idx)
			5'h00: v = 11'h000;
			5'h01: v = 11'h062;
			5'h02: v = 11'h0C3;
			5'h03: v = 11'h122;
			5'h04: v = 11'h17F;
			5'h05: v = 11'h1D7;
			5'h06: v = 11'h22C;
			5'h07: v = 11'h27A;
			5'h08: v = 11'h2C3;
			5'h09: v = 11'h305;
			5'h0A: v = 11'h33F;
			5'h0B: v = 11'h372;
			5'h0C: v = 11'h39C;
			5'h0D: v = 11'h3BD;
			5'h0E: v = 11'h3D5;
			5'h0F: v = 11'h3E3;
			default: v = `MCT_FULL_SCALE;
		endcase
		return v;
	endfunction

	// Second half of the turn mirrors the first with both coils negated
	function automatic mct_pkg::mct_cur_t coil_y_of(input mct_pkg::mct_pos_t p);
		logic [4:0] h;
		mct_pkg::mct_cur_t m;
		h = p[4:0];
		m = (h <= `MCT_HALF_TURN) ? quarter_sine(h) : quarter_sine(5'h00 - h);
		return p[5] ? -m : m;
	endfunction

	function automatic mct_pkg::mct_cur_t coil_x_of(input mct_pkg::mct_pos_t p);
		logic [4:0] h;
		mct_pkg::mct_cur_t m;
		h = p[4:0];
		m = (h <= `MCT_HALF_TURN) ? quarter_sine(`MCT_HALF_TURN - h)
			: -quarter_sine(h - `MCT_HALF_TURN);
		return p[5] ? -m : m;
	endfunction

	logic step_sync1_reg;
	logic step_sync2_reg;
	logic step_prev_reg;
	logic dir_sync1_reg;
	logic dir_sync2_reg;
	mct_pkg::mct_pos_t pos_reg;
	mct_pkg::mct_pos_t pos_next;
	logic cmd_reg;
	logic cmd_next;
	mct_pkg::mct_cur_t coil_x_reg;
	mct_pkg::mct_cur_t coil_y_reg;

	// Decode of resolution, trigger and direction
	wire logic pin_rise = step_sync2_reg & ~step_prev_reg;
	wire logic trigger = pin_rise | cmd_reg;
	wire logic dir_eff = dir_sync2_reg ^ DIRECTION_POLARITY_BIT_I;
	// Undefined select codes fall back to sixteenths
	wire mct_pkg::mct_shift_t res_shift =
		(STEP_RESOLUTION_SELECT_I > `MCT_RES_FULL) ? 3'h0
		: STEP_RESOLUTION_SELECT_I;
	wire mct_pkg::mct_pos_t stride = 6'h01 << res_shift;
	wire mct_pkg::mct_pos_t low_mask = stride - 6'h01;
	wire mct_pkg::mct_pos_t grid_pos = pos_reg & ~low_mask;
	wire logic on_grid = (pos_reg & low_mask) == 6'h00;
	// Off grid: forward lands on the next point up, backward on the floor
	wire mct_pkg::mct_pos_t fwd_pos = grid_pos + stride;
	wire mct_pkg::mct_pos_t back_pos = on_grid ? grid_pos - stride : grid_pos;
	wire mct_pkg::mct_pos_t step_pos = dir_eff ? back_pos : fwd_pos;

	// Position write wins over a trigger in the same cycle
	assign pos_next = POSITION_WRITE_I ? POSITION_WDATA_I
		: trigger ? step_pos : pos_reg;
	// A new write of one survives the cycle that clears the bit
	assign cmd_next = STEP_COMMAND_BIT_SET_I;

	// Only the second stage of each synchroniser feeds logic
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			step_sync1_reg <= 1'b0;
			step_sync2_reg <= 1'b0;
			step_prev_reg <= 1'b0;
			dir_sync1_reg <= 1'b0;
			dir_sync2_reg <= 1'b0;
		end else begin
			step_sync1_reg <= STEP_TRIGGER_PIN_I;
			step_sync2_reg <= step_sync1_reg;
			step_prev_reg <= step_sync2_reg;
			dir_sync1_reg <= DIRECTION_PIN_I;
			dir_sync2_reg <= dir_sync1_reg;
		end
	end

	// Currents come from the next position so they never lag it
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pos_reg <= `MCT_RESET_POS;
			cmd_reg <= 1'b0;
			coil_x_reg <= `MCT_RESET_CUR;
			coil_y_reg <= `MCT_RESET_CUR;
		end else begin
			pos_reg <= pos_next;
			cmd_reg <= cmd_next;
			coil_x_reg <= coil_x_of(pos_next);
			coil_y_reg <= coil_y_of(pos_next);
		end
	end

	assign TRANSLATOR_POSITION_O = pos_reg;
	assign STEP_COMMAND_BIT_O = cmd_reg;
	assign DIRECTION_PIN_FLAG_O = dir_sync2_reg;
	assign COIL_X_O = coil_x_reg;
	assign COIL_Y_O = coil_y_reg;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_step_fwd16;
		trigger && !POSITION_WRITE_I && res_shift == 3'h0 && !dir_eff;
	endsequence
	sequence s_step_back16;
		trigger && !POSITION_WRITE_I && res_shift == 3'h0 && dir_eff;
	endsequence

	property p_reset_pos;
		@(posedge CLK_I) disable iff (1'b0)
		!RST_N_I |=> pos_reg == 6'h08 && coil_x_reg == 11'sd707 && coil_y_reg == 11'sd707;
	endproperty
	a_reset_pos: assert property (p_reset_pos) else $error("reset position wrong");
	property p_fwd;
		s_step_fwd16 |=> pos_reg == $past(pos_reg) + 6'h01;
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward step wrong");
	property p_back;
		s_step_back16 |=> pos_reg == $past(pos_reg) - 6'h01;
	endproperty
	a_back: assert property (p_back) else $error("backward step wrong");
	property p_grid;
		trigger && !POSITION_WRITE_I |=> (pos_reg & $past(low_mask)) == 6'h00;
	endproperty
	a_grid: assert property (p_grid) else $error("position off grid");
	property p_write;
		POSITION_WRITE_I |=> pos_reg == $past(POSITION_WDATA_I);
	endproperty
	a_write: assert property (p_write) else $error("position write lost");
	property p_cmd_clear;
		cmd_reg && !STEP_COMMAND_BIT_SET_I |=> !cmd_reg;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear) else $error("command bit stuck");
	property p_hold;
		!trigger && !POSITION_WRITE_I |=> $stable(pos_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("position moved untriggered");
	property p_table;
		(pos_reg == 6'h10 |-> coil_y_reg == 11'sd1000 && coil_x_reg == 11'sd0)
		and (pos_reg == 6'h21 |-> coil_y_reg == -11'sd98 && coil_x_reg == -11'sd995);
	endproperty
	a_table: assert property (p_table) else $error("coil table mismatch");
	property p_full_stride;
		trigger && !POSITION_WRITE_I && res_shift == 3'h4 && !dir_eff
		|=> pos_reg == (($past(pos_reg) & 6'h30) + 6'h10);
	endproperty
	a_full_stride: assert property (p_full_stride) else $error("full step stride");
	// Set beats the automatic clear, so a repeated pulse re-arms the bit
	property p_cmd_set;
		STEP_COMMAND_BIT_SET_I |=> cmd_reg;
	endproperty
	a_cmd_set: assert property (p_cmd_set) else $error("command bit not set");
	// A write in the same cycle as a trigger drops the trigger
	property p_write_wins;
		POSITION_WRITE_I && trigger |=> pos_reg == $past(POSITION_WDATA_I);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("write lost to trigger");
	property p_mid_table;
		(pos_reg == 6'h08 |-> coil_x_reg == 11'sd707 && coil_y_reg == 11'sd707)
		and (pos_reg == 6'h38 |-> coil_y_reg == -11'sd707 && coil_x_reg == 11'sd707);
	endproperty
	a_mid_table: assert property (p_mid_table) else $error("coil table diagonal");
	property p_full_back;
		trigger && !POSITION_WRITE_I && res_shift == 3'h4 && dir_eff && pos_reg[3:0] == 4'h0
		|=> pos_reg == $past(pos_reg) - 6'h10;
	endproperty
	a_full_back: assert property (p_full_back) else $error("full step backward");
endmodule

// ---- testbench/mct_ctrl_model.sv ----
// Controller-side model driving the step and direction pins.
// Assumes the translator's clock and reset; requests come from the bench.
`timescale 1ns/100ps
module mct_ctrl_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests from the bench
	input wire logic step_req_i,
	input wire logic dir_i,
	// Pins
	output logic step_pin_o,
	output logic dir_pin_o
);
	logic [2:0] cnt_reg;
	// Pulse held well above the minimum width so no edge is missed
	always_ff @(posedge clk_i) begin
		dir_pin_o <= dir_i;
		if (!rst_n_i) begin
			step_pin_o <= 1'b0;
			cnt_reg <= 3'h0;
		end else if (step_req_i) begin
			step_pin_o <= 1'b1;
			cnt_reg <= 3'h4;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end else begin
			step_pin_o <= 1'b0;
		end
	end
endmodule

// ---- testbench/microstep_current_translator_tb.sv ----
// Self-checking bench for the step translator.
// Assumes the controller model drives the pins; control bits are driven here.
`timescale 1ns/100ps
module microstep_current_translator_tb;
	logic CLK_I = 0, RST_N_I = 0, step_req = 0, dir = 0, cset = 0, pwr = 0, pol = 0;
	logic pin, dpin, cmd, dflag;
	logic [2:0] res = 3'h0;
	logic [5:0] wd = 6'h00, pos;
	logic signed [10:0] cx, cy;
	int n_errors = 0, checks = 0, cyc = 0;
	mct_translator mct_translator_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
		.STEP_TRIGGER_PIN_I(pin), .DIRECTION_PIN_I(dpin), .STEP_RESOLUTION_SELECT_I(res),
		.DIRECTION_POLARITY_BIT_I(pol), .STEP_COMMAND_BIT_SET_I(cset), .POSITION_WRITE_I(pwr),
		.POSITION_WDATA_I(wd), .TRANSLATOR_POSITION_O(pos), .STEP_COMMAND_BIT_O(cmd),
		.DIRECTION_PIN_FLAG_O(dflag), .COIL_X_O(cx), .COIL_Y_O(cy));
	mct_ctrl_model mct_ctrl_model_inst (.clk_i(CLK_I), .rst_n_i(RST_N_I), .step_req_i(step_req),
		.dir_i(dir), .step_pin_o(pin), .dir_pin_o(dpin));
	initial forever #5 CLK_I = ~CLK_I;
	task tick;
		@(posedge CLK_I);
		#1;
	endtask
	task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	// Command bit must show for one cycle before the position moves
	task cstep(input logic [5:0] e);
		cset = 1;
		tick;
		cset = 0;
		chk("cmd", 11'h001, {10'h000, cmd});
		tick;
		chk("pos", {5'h00, e}, {5'h00, pos});
		chk("cmd", 11'h000, {10'h000, cmd});
	endtask
	task wr(input logic [5:0] d);
		wd = d;
		pwr = 1;
		tick;
		pwr = 0;
	endtask
	task pstep;
		step_req = 1;
		tick;
		step_req = 0;
		repeat (8) tick;
	endtask
	task final_report;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			final_report;
		end
	end
	initial begin
		repeat (10) tick;
		RST_N_I = 1;
		tick;
		chk("pos", 11'h008, {5'h00, pos});
		chk("x", 11'h2C3, cx);
		chk("y", 11'h2C3, cy);
		chk("dflag", 11'h000, {10'h000, dflag});
		cstep(6'h09);
		res = 3'h4;
		cstep(6'h10);
		chk("x", 11'h000, cx);
		chk("y", 11'h3E8, cy);
		for (int c = 0; c < 5; c++) begin
			res = c[2:0];
			wr(6'h00);
			cstep(6'h01 << c);
		end
		res = 3'h7;
		wr(6'h10);
		cstep(6'h11);
		chk("x", 11'h79E, cx);
		chk("y", 11'h3E3, cy);
		cset = 1;
		tick;
		cset = 0;
		wr(6'h0C);
		chk("pos", 11'h00C, {5'h00, pos});
		pol = 1;
		res = 3'h0;
		wr(6'h00);
		cstep(6'h3F);
		res = 3'h4;
		wr(6'h00);
		cstep(6'h30);
		res = 3'h2;
		wr(6'h05);
		cstep(6'h04);
		res = 3'h4;
		repeat (3) tick;
		chk("pos", 11'h004, {5'h00, pos});
		res = 3'h0;
		dir = 1;
		wr(6'h20);
		repeat (5) tick;
		chk("dflag", 11'h001, {10'h000, dflag});
		pstep;
		chk("pos", 11'h021, {5'h00, pos});
		pol = 0;
		pstep;
		chk("pos", 11'h020, {5'h00, pos});
		chk("x", 11'h418, cx);
		wr(6'h28);
		chk("pos", 11'h028, {5'h00, pos});
		chk("x", 11'h53D, cx);
		RST_N_I = 0;
		repeat (3) tick;
		RST_N_I = 1;
		tick;
		chk("pos", 11'h008, {5'h00, pos});
		chk("x", 11'h2C3, cx);
		final_report;
	end
endmodule
